// ===== core/nvtr_pkg.sv
// What this block does
// RULE1 - Three setting registers at F8h, F9h, FAh
// RULE2 - Settings nonvolatile, factory value 7Fh
// RULE3 - Low seven bits select 128 positions
// RULE4 - Values above 7Fh set high-impedance bit
// RULE5 - 00h low switch state, 80h high-impedance
// RULE6 - Nonvolatile write starts only after stop
// RULE7 - Address-select pins form part of slave address
// RULE8 - Address byte 1010, pin bits, R/W; match
// RULE9 - Master writes address, register, data, stop
// RULE10 - Busy writing: ignore bus, withhold acknowledge
// RULE11 - Read: dummy write, restart, read, NACK, stop
// RULE12 - Read returns all eight stored bits
`default_nettype none
package nvtr_pkg;
    // Bus address fields, factory value and setting layout
    localparam logic [3:0] NVTR_DEV_PATTERN = 4'ha;
    localparam logic [7:0] NVTR_TRIM0_ADDR = 8'hf8;
    localparam logic [7:0] NVTR_TRIM1_ADDR = 8'hf9;
    localparam logic [7:0] NVTR_TRIM2_ADDR = 8'hfa;
    localparam logic [7:0] NVTR_TRIM_RESET = 8'h7f;
    localparam int NVTR_HIZ_BIT = 7;
    localparam int NVTR_NUM_TRIM = 3;
    localparam int NVTR_ADDR_PINS = 3;
    // Timing: nonvolatile write time and clock
    localparam int NVTR_CLK_PERIOD_NS = 50;
    localparam int NVTR_NV_WRITE_TIME_US = 10000;
    localparam int NVTR_NV_WRITE_CYCLES = (NVTR_NV_WRITE_TIME_US * 1000 + NVTR_CLK_PERIOD_NS - 1) / NVTR_CLK_PERIOD_NS;
    localparam int NVTR_BUSY_CNT_W = 18;

    // One resistor setting: high-impedance bit over position
    typedef struct packed {
        logic hiz_select_bit;
        logic [6:0] position;
    } nvtr_setting_s;

    // Serial slave states
    typedef enum logic [5:0] {
        NVTR_ST_IDLE = 6'h01,
        NVTR_ST_RX = 6'h02,
        NVTR_ST_ACK = 6'h04,
        NVTR_ST_TX = 6'h08,
        NVTR_ST_MACK = 6'h10,
        NVTR_ST_BUSY = 6'h20
    } nvtr_state_e;
endpackage
`default_nettype wire

// ===== core/nvtr_sync.sv
`timescale 1ns/10ps
`default_nettype none
module nvtr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [1:0][WIDTH-1:0] stage_reg;

    // Two flops; the first is read only by the second
    always_ff @(posedge clk) begin
        if (rst) begin
            stage_reg <= {RESET_VAL, RESET_VAL};
        end else begin
            stage_reg <= {stage_reg[0], async_in};
        end
    end

    assign sync_out = stage_reg[1];
endmodule // nvtr_sync
`default_nettype wire

// ===== core/nvtr_regs.sv
`timescale 1ns/10ps
`default_nettype none
module nvtr_regs #(
    parameter int NUM_ADDR_PINS = nvtr_pkg::NVTR_ADDR_PINS,
    parameter int NV_WRITE_CYCLES = nvtr_pkg::NVTR_NV_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_pin_0,
    input wire logic addr_select_pin_1,
    input wire logic addr_select_pin_2,
    output nvtr_pkg::nvtr_setting_s [2:0] trim_setting,
    output logic nv_write_busy
);
    import nvtr_pkg::*;

    typedef struct packed {
        nvtr_state_e st;
        logic scl_d;
        logic sda_d;
        logic [3:0] bitcnt;
        logic [1:0] byte_idx;
        logic [7:0] shreg;
        logic rw;
        logic [7:0] reg_ptr;
        logic wpend;
        logic [1:0] wr_idx;
        logic [7:0] wdata;
        logic [NVTR_BUSY_CNT_W-1:0] busy_cnt;
        logic sda_oe;
        logic sda_out;
        logic busy;
        nvtr_setting_s [2:0] nv;
    } nvtr_core_s;

    localparam logic [NVTR_BUSY_CNT_W-1:0] BUSY_LOAD = NVTR_BUSY_CNT_W'(NV_WRITE_CYCLES - 1);

    nvtr_core_s r_reg;
    nvtr_core_s r_next;
    logic [4:0] pins_sync;
    logic s_scl;
    logic s_sda;
    logic [2:0] pin_addr;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic ptr_mapped;
    logic [1:0] ptr_idx;
    logic [7:0] rd_byte;
    logic addr_match;

    // Bus and address pins cross into the clk domain; idle bus is high
    nvtr_sync #(
        .WIDTH(5),
        .RESET_VAL(5'h03)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({addr_select_pin_2, addr_select_pin_1, addr_select_pin_0, sda_in, scl_in}),
        .sync_out(pins_sync)
    );

    assign s_scl = pins_sync[0];
    assign s_sda = pins_sync[1];

    // RULE7 address pins wired
    // Smaller variant has one pin; upper bits then expected zero
    assign pin_addr = (NUM_ADDR_PINS >= 3) ? pins_sync[4:2] : {2'b00, pins_sync[2]};

    // Edges and bus conditions from sampled lines
    assign scl_rise = s_scl & ~r_reg.scl_d;
    assign scl_fall = ~s_scl & r_reg.scl_d;
    assign bus_start = s_scl & r_reg.scl_d & r_reg.sda_d & ~s_sda;
    assign bus_stop = s_scl & r_reg.scl_d & ~r_reg.sda_d & s_sda;

    // RULE1 register decode
    assign ptr_mapped = (r_reg.reg_ptr >= NVTR_TRIM0_ADDR) && (r_reg.reg_ptr <= NVTR_TRIM2_ADDR);
    assign ptr_idx = r_reg.reg_ptr[1:0] - NVTR_TRIM0_ADDR[1:0];

    // RULE12 full byte readback
    // Unmapped addresses read as zero
    assign rd_byte = ptr_mapped ? r_reg.nv[ptr_idx] : 8'h00;

    // RULE8 address byte match
    assign addr_match = (r_reg.shreg[7:4] == NVTR_DEV_PATTERN) && (r_reg.shreg[3:1] == pin_addr);

    // Next-state logic of the serial slave
    always_comb begin
        r_next = r_reg;
        r_next.scl_d = s_scl;
        r_next.sda_d = s_sda;
        if (r_reg.st == NVTR_ST_BUSY) begin
            // RULE10 ignore bus while writing
            // Acknowledge withheld since sda stays released
            r_next.sda_oe = 1'b0;
            if (r_reg.busy_cnt == '0) begin
                // RULE2 commit to nonvolatile store
                // RULE4 eight bits kept, MSB is high-impedance
                r_next.nv[r_reg.wr_idx] = r_reg.wdata;
                r_next.wpend = 1'b0;
                r_next.st = NVTR_ST_IDLE;
            end else begin
                r_next.busy_cnt = r_reg.busy_cnt - 1'b1;
            end
        end else if (bus_stop) begin
            r_next.sda_oe = 1'b0;
            // RULE6 write begins at stop
            if (r_reg.wpend) begin
                r_next.st = NVTR_ST_BUSY;
                r_next.busy_cnt = BUSY_LOAD;
            end else begin
                r_next.st = NVTR_ST_IDLE;
            end
        end else if (bus_start) begin
            // Start or repeated start; pending data waits for stop
            r_next.st = NVTR_ST_RX;
            r_next.sda_oe = 1'b0;
            r_next.bitcnt = 4'h0;
            r_next.byte_idx = 2'h0;
        end else begin
            case (r_reg.st)
                NVTR_ST_IDLE: begin
                    r_next.sda_oe = 1'b0;
                end
                NVTR_ST_RX: begin
                    if (scl_rise && (r_reg.bitcnt != 4'h8)) begin
                        r_next.shreg = {r_reg.shreg[6:0], s_sda};
                        r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    end else if (scl_fall && (r_reg.bitcnt == 4'h8)) begin
                        r_next.bitcnt = 4'h0;
                        case (r_reg.byte_idx)
                            2'h0: begin
                                if (addr_match) begin
                                    r_next.rw = r_reg.shreg[0];
                                    r_next.sda_oe = 1'b1;
                                    r_next.st = NVTR_ST_ACK;
                                end else begin
                                    // Not ours: sit out until next start
                                    r_next.st = NVTR_ST_IDLE;
                                end
                            end
                            2'h1: begin
                                r_next.reg_ptr = r_reg.shreg;
                                r_next.sda_oe = 1'b1;
                                r_next.st = NVTR_ST_ACK;
                            end
                            2'h2: begin
                                // RULE9 single data byte latched
                                // Data to an unmapped address is acknowledged and dropped
                                if (ptr_mapped) begin
                                    r_next.wdata = r_reg.shreg;
                                    r_next.wr_idx = ptr_idx;
                                    r_next.wpend = 1'b1;
                                end
                                r_next.sda_oe = 1'b1;
                                r_next.st = NVTR_ST_ACK;
                            end
                            default: begin
                                // Extra bytes are not acknowledged
                                r_next.st = NVTR_ST_IDLE;
                            end
                        endcase
                    end
                end
                NVTR_ST_ACK: begin
                    if (scl_fall) begin
                        r_next.bitcnt = 4'h0;
                        if ((r_reg.byte_idx == 2'h0) && r_reg.rw) begin
                            // RULE11 read after restart
                            r_next.shreg = rd_byte;
                            r_next.sda_oe = ~rd_byte[7];
                            r_next.st = NVTR_ST_TX;
                        end else begin
                            r_next.sda_oe = 1'b0;
                            r_next.byte_idx = r_reg.byte_idx + 2'h1;
                            r_next.st = NVTR_ST_RX;
                        end
                    end
                end
                NVTR_ST_TX: begin
                    // Bits change on scl fall, held through high
                    if (scl_fall) begin
                        if (r_reg.bitcnt == 4'h7) begin
                            r_next.sda_oe = 1'b0;
                            r_next.st = NVTR_ST_MACK;
                        end else begin
                            r_next.bitcnt = r_reg.bitcnt + 4'h1;
                            r_next.shreg = {r_reg.shreg[6:0], 1'b0};
                            r_next.sda_oe = ~r_reg.shreg[6];
                        end
                    end
                end
                NVTR_ST_MACK: begin
                    // NACK ends the read; ACK resends the same byte
                    if (scl_rise && s_sda) begin
                        r_next.st = NVTR_ST_IDLE;
                    end else if (scl_fall) begin
                        r_next.bitcnt = 4'h0;
                        r_next.shreg = rd_byte;
                        r_next.sda_oe = ~rd_byte[7];
                        r_next.st = NVTR_ST_TX;
                    end
                end
                default: begin
                    r_next.st = NVTR_ST_IDLE;
                    r_next.sda_oe = 1'b0;
                end
            endcase
        end
        r_next.busy = (r_next.st == NVTR_ST_BUSY);
        r_next.sda_out = 1'b0;
    end

    // State register; reset stands for the factory-fresh device
    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.st <= NVTR_ST_IDLE;
            r_reg.scl_d <= 1'b1;
            r_reg.sda_d <= 1'b1;
            // RULE2 factory value 7Fh
            // RULE3 position 7Fh, maximum
            r_reg.nv <= {NVTR_NUM_TRIM{NVTR_TRIM_RESET}};
        end else begin
            r_reg <= r_next;
        end
    end

    // RULE5 settings drive switch state
    // 00h gives the low state, 80h high impedance
    assign trim_setting = r_reg.nv;
    assign sda_oe = r_reg.sda_oe;
    assign sda_out = r_reg.sda_out;
    assign nv_write_busy = r_reg.busy;
endmodule // nvtr_regs
`default_nettype wire

// ===== bench/nvtr_properties.sv
`timescale 1ns/10ps
`default_nettype none
module nvtr_properties import nvtr_pkg::*; #(
    parameter int NV_WRITE_CYCLES = 400
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire nvtr_pkg::nvtr_setting_s [2:0] trim_setting,
    input wire logic nv_write_busy
);
    // Busy length in a counter, too long for a repetition
    logic [17:0] busy_cnt_reg;
    always_ff @(posedge clk) begin
        busy_cnt_reg <= (rst || !nv_write_busy) ? 18'h0 : busy_cnt_reg + 18'h1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Acknowledge or data bit held across the high phase
    sequence s_ack_hold;
        sda_oe [*4];
    endsequence
    property p_reset_vals;
        $fell(rst) |-> trim_setting == {3{NVTR_TRIM_RESET}} && !nv_write_busy && !sda_oe;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");
    property p_busy_len;
        $fell(nv_write_busy) |-> busy_cnt_reg >= NV_WRITE_CYCLES - 1 && busy_cnt_reg <= NV_WRITE_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write time wrong");
    property p_busy_max;
        busy_cnt_reg <= NV_WRITE_CYCLES + 1;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("write never ends");
    property p_trim_moves;
        !$stable(trim_setting) |-> $fell(nv_write_busy);
    endproperty
    a_trim_moves: assert property (p_trim_moves) else $error("setting moved outside write end");
    property p_quiet_busy;
        nv_write_busy |-> !sda_oe;
    endproperty
    a_quiet_busy: assert property (p_quiet_busy) else $error("bus driven while busy");
    property p_after_stop;
        $rose(nv_write_busy) |-> $past(scl_in, 2) && $past(sda_in, 2);
    endproperty
    a_after_stop: assert property (p_after_stop) else $error("write began without stop");
    property p_ack_hold;
        $rose(sda_oe) |-> s_ack_hold;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("drive too short");
    property p_drive_low;
        sda_oe |-> !sda_out;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("data driven high");
endmodule // nvtr_properties
bind nvtr_regs nvtr_properties #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_prop (.clk(clk), .rst(rst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .trim_setting(trim_setting), .nv_write_busy(nv_write_busy));
`default_nettype wire

// ===== bench/nvtr_master.sv
`timescale 1ns/10ps
`default_nettype none
module nvtr_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // Bus idle; clock stands high outside frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic q(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Works from idle and as repeated start
    task automatic start();
        sda_pull = 1'b0;
        q(4);
        scl = 1'b1;
        q(4);
        sda_pull = 1'b1;
        q(4);
        scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic [8:0] sh;
        sh = {tx, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            q(2);
            sda_pull = !sh[i];
            q(2);
            scl = 1'b1;
            q(4);
            sh[i] = sda;
            scl = 1'b0;
        end
        rx = sh[8:1];
        ack = !sh[0];
    endtask
    task automatic stop();
        q(2);
        sda_pull = 1'b1;
        q(2);
        scl = 1'b1;
        q(4);
        sda_pull = 1'b0;
        q(8);
    endtask
    task automatic wr(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d, output logic ok);
        logic [7:0] x;
        logic a0, a1, a2;
        start();
        xfer(dev, x, a0);
        xfer(ra, x, a1);
        xfer(d, x, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [7:0] dev, input logic [7:0] ra, output logic [7:0] d, output logic ok);
        logic [7:0] x;
        logic a0, a1, a2, a3;
        start();
        xfer(dev, x, a0);
        xfer(ra, x, a1);
        start();
        xfer(dev | 8'h01, x, a2);
        xfer(8'hff, d, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule // nvtr_master
`default_nettype wire

// ===== bench/nvtr_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module nvtr_regs_tb;
    import nvtr_pkg::*;
    typedef struct packed {logic [7:0] ra; logic [7:0] d; logic [1:0] idx; logic [7:0] exp;} nvtr_row_s;
    localparam nvtr_row_s ROWS [5] = '{'{8'hf8, 8'h00, 2'h0, 8'h00}, '{8'hf9, 8'h7f, 2'h1, 8'h7f},
        '{8'hf8, 8'hc5, 2'h0, 8'hc5}, '{8'hf9, 8'h01, 2'h1, 8'h01}, '{8'hfa, 8'h80, 2'h2, 8'h80}};
    // One with wrong pin bits, one with wrong fixed pattern
    localparam logic [7:0] BAD_DEV [2] = '{8'ha8, 8'h3a};
    // Fixed pattern 1010, pins 101, write
    localparam logic [7:0] DEV = 8'haa;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] pins = 3'b101;
    // Second device, one-pin variant; its upper pins are set to show they are ignored
    logic [2:0] pins_s = 3'b110;
    logic scl, m_pull, sda, sda_out, sda_oe, busy, ok;
    logic sda_oe_s, busy_s;
    logic [7:0] rx;
    nvtr_setting_s [2:0] trim;
    nvtr_setting_s [2:0] trim_s;
    int bad_count = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    // Pull-up: low when any of the three parties pulls
    assign sda = !(m_pull || sda_oe || sda_oe_s);
    nvtr_master u_mst (.clk(clk), .sda(sda), .scl(scl), .sda_pull(m_pull));
    nvtr_regs #(.NUM_ADDR_PINS(3), .NV_WRITE_CYCLES(400)) u_dut (.clk(clk), .rst(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_0(pins[0]),
        .addr_select_pin_1(pins[1]), .addr_select_pin_2(pins[2]), .trim_setting(trim), .nv_write_busy(busy));
    nvtr_regs #(.NUM_ADDR_PINS(1), .NV_WRITE_CYCLES(400)) u_dut_small (.clk(clk), .rst(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe_s), .addr_select_pin_0(pins_s[0]),
        .addr_select_pin_1(pins_s[1]), .addr_select_pin_2(pins_s[2]), .trim_setting(trim_s),
        .nv_write_busy(busy_s));
    task automatic ck(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 3; i++) begin
            ck(trim[i], NVTR_TRIM_RESET);
            ck(trim_s[i], NVTR_TRIM_RESET);
        end
        $display("reset test done");
    endtask
    // Bounded wait for the write to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while ((busy | busy_s) !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        ck({7'h0, busy | busy_s}, 8'h00);
    endtask
    task automatic report_and_stop();
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        foreach (ROWS[i]) begin
            u_mst.wr(DEV, ROWS[i].ra, ROWS[i].d, ok);
            ck({7'h0, ok}, 8'h01);
            wait_idle();
            ck(trim[ROWS[i].idx], ROWS[i].exp);
            u_mst.rd(DEV, ROWS[i].ra, rx, ok);
            ck(rx, ROWS[i].exp);
        end
        $display("row tests done");
        u_mst.start();
        u_mst.xfer(DEV, rx, ok);
        u_mst.xfer(8'hfa, rx, ok);
        u_mst.xfer(8'h3c, rx, ok);
        repeat (20) @(negedge clk);
        ck({7'h0, busy}, 8'h00);
        u_mst.stop();
        ck({7'h0, busy}, 8'h01);
        ck(trim[2], 8'h80);
        u_mst.start();
        u_mst.xfer(DEV, rx, ok);
        u_mst.stop();
        ck({7'h0, ok}, 8'h00);
        wait_idle();
        ck(trim[2], 8'h3c);
        $display("stop and busy test done");
        foreach (BAD_DEV[i]) begin
            u_mst.wr(BAD_DEV[i], 8'hf8, 8'h11, ok);
            ck({7'h0, ok}, 8'h00);
        end
        ck({7'h0, busy}, 8'h00);
        pins = 3'b010;
        u_mst.wr(8'ha4, 8'hf8, 8'h55, ok);
        ck({7'h0, ok}, 8'h01);
        wait_idle();
        ck(trim[0], 8'h55);
        // one-pin variant address
        // Address 101000 a0 w; only the small device may take it
        u_mst.wr(8'ha0, 8'hf9, 8'h5a, ok);
        ck({7'h0, ok}, 8'h01);
        wait_idle();
        ck(trim_s[1], 8'h5a);
        ck(trim[1], 8'h01);
        $display("address test done");
        do_reset();
        report_and_stop();
    end
    // Run needs about 0.4 ms
    initial begin
        #2000000;
        bad_count++;
        $display("BAD t=%0t watchdog", $time);
        report_and_stop();
    end
endmodule // nvtr_regs_tb
`default_nettype wire
